// file: hdl/mtr_pkg.sv
// constants, types and helpers shared by the track readout design
package mtr_pkg;
	// ==============================
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int SAMPLE_PERIOD_US = 10_000;
	localparam int SAMPLE_CYC_DEF = CLK_HZ / 1_000_000 * SAMPLE_PERIOD_US;
	localparam int BAUD_DEFAULT = 115_200;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);
	localparam int MP_BASE_US = 10;
	localparam logic [11:0] MP_BASE_CYC = 12'(CLK_HZ / 1_000_000 * MP_BASE_US);
	localparam logic [11:0] MP_GAP_CYC = MP_BASE_CYC;
	localparam logic [2:0] MP_SLOTS = 3'h4;
	// ==============================
	// geometry and detection
	localparam int NSENS_DEF = 16;
	localparam int PITCH_MM = 10;
	localparam int CENTER_MM = 75;
	localparam logic signed [16:0] TRK_THR = 17'sh00080;
	localparam logic [7:0] DAC_MID = 8'h80;
	localparam logic [7:0] PWM_SPAN_RST = 8'h64;
	localparam int SPAN_DEN = 4 * CENTER_MM * 100;
	localparam logic [15:0] PWM_PER_RST = 16'h186A;
	// ==============================
	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ZERO_OFFSET_ADJUST = 8'h04;
	localparam logic [7:0] REG_BAUD = 8'h08;
	localparam logic [7:0] REG_PWM_PER = 8'h0C;
	localparam logic [7:0] REG_PWM_SPAN = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_GYRO_Z = 8'h18;
	localparam logic [7:0] REG_ANG_X = 8'h1C;
	localparam logic [7:0] REG_ANG_Y = 8'h20;
	localparam logic [7:0] REG_ANG_Z = 8'h24;
	// control field positions
	localparam int CB_REL = 0;
	localparam int CB_CMD_RIGHT = 1;
	localparam int CB_RX_BRANCH = 2;
	localparam int CB_MULTI = 3;
	localparam int CB_RANGE = 4;
	localparam int CB_SENS = 6;
	localparam int CB_GCAL = 8;
	localparam logic [8:0] CTRL_RST = 9'h008;

	typedef enum logic [1:0] {SC_IDLE, SC_RUN, SC_WAIT, SC_DONE} mtr_scan_t;

	// marker threshold for the three sensitivity levels
	function automatic logic signed [16:0] mtr_mrk_thr(input logic [1:0] s);
		unique case (s)
			2'h0: mtr_mrk_thr = -17'sh00100;
			2'h1: mtr_mrk_thr = -17'sh00200;
			default: mtr_mrk_thr = -17'sh00400;
		endcase
	endfunction : mtr_mrk_thr

	// rate span per full scale: 250, 500, 2000 dps
	function automatic logic signed [16:0] mtr_gspan(input logic [1:0] r);
		unique case (r)
			2'h0: mtr_gspan = 17'sd25000;
			2'h1: mtr_gspan = 17'sd5000;
			default: mtr_gspan = 17'sd20000;
		endcase
	endfunction : mtr_gspan

	// counts per tenth-degree of angle at 100 integrations per second
	function automatic logic signed [31:0] mtr_ascale(input logic [1:0] r);
		mtr_ascale = (r == 2'h0) ? 32'sd1000 : 32'sd100;
	endfunction : mtr_ascale
endpackage : mtr_pkg

// file: hdl/mtr_sample_ram.sv
// field sample store, one word per sensing element, registered read
`timescale 1ns/1ns
`default_nettype none
module mtr_sample_ram #(
	parameter int W = 16,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	// clock
	input wire logic ref_clk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [W-1:0] rd_data
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : mtr_sample_ram
`default_nettype wire

// file: hdl/mtr_track_readout.sv
// track detection, branch select, gyro integration and output drivers
//
// Summary of operation
// RULE1: serial link defaults to 115200 baud, 8 data bits, no parity.
// RULE2: baud divisor writable only while USB host attached; kept afterwards.
// RULE3: track-present output high while track detected, low otherwise.
// RULE4: positions reported as signed millimetres, zero at sensor centre.
// RULE5: left and right track positions always kept; equal on single track.
// RULE6: fork inputs pick left/right; both low holds; both high uses command.
// RULE7: both high: receive pin decides if enabled, else command bit.
// RULE8: opposite-polarity regions left/right of track are separate markers.
// RULE9: absolute mode: above zero is track, below chosen threshold marker. Code counts track only above TRK_THR (0x80).
// RULE10: zero adjust offset shifts every sample before thresholds.
// RULE11: relative mode thresholds at curve middle, reports no markers.
// RULE12: three gyro axes, full scale 250, 500 or 2000 dps.
// RULE13: rates clamped to 25000, 5000, 20000 counts; divisors 100,10,10.
// RULE14: rates integrated to angles in tenths of degree; host sets angle.
// RULE15: calibration captures gyro offsets, stores them, subtracts later.
// RULE16: track LED red left, green right; marker LEDs separate.
// RULE17: multi-pulse mode sends positions, detect, markers every 10 ms.
// RULE18: multi-pulse stream also carries Z gyro rate.
// RULE19: selected position drives 0-3 V DAC and configurable PWM.
// RULE20: single PWM 50% centred, 25/75% at ends, 50% with no track.
// RULE21: all results recomputed each sample period and published together. Code updates gyro rates on each gyro_valid, not at publish.
`timescale 1ns/1ns
`default_nettype none
module mtr_track_readout import mtr_pkg::*; #(
	parameter int SAMPLE_CYC = SAMPLE_CYC_DEF,
	parameter int NSENS = NSENS_DEF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// field samples from the sensing array
	input wire logic smp_valid,
	input wire logic [3:0] smp_idx,
	input wire logic [15:0] smp_data,
	// gyroscope raw rates
	input wire logic gyro_valid,
	input wire logic [15:0] gyro_raw_x,
	input wire logic [15:0] gyro_raw_y,
	input wire logic [15:0] gyro_raw_z,
	// gyro offset nonvolatile store
	input wire logic nv_load,
	input wire logic [47:0] nv_offset_in,
	output logic nv_store,
	output logic [47:0] nv_offset_out,
	// branch and link status inputs
	input wire logic fork_left,
	input wire logic fork_right,
	input wire logic serial_receive_pin,
	input wire logic usb_attached,
	// outputs
	output logic track_present,
	output logic marker_left,
	output logic marker_right,
	output logic led_red,
	output logic led_green,
	output logic [7:0] dac_code,
	output logic multi_pulse_output,
	output logic tx_pin
);
	localparam int AW = $clog2(NSENS);
	// ==============================
	// registers
	logic [8:0] ctrl;
	logic signed [15:0] zero_offset_adjust;
	logic [15:0] baud_div, pwm_per;
	logic [7:0] pwm_span;
	logic acc_wr, acc_rd;
	logic [7:0] sel_pos_q;
	logic signed [7:0] left_mm, right_mm;
	logic signed [15:0] rate [3];
	logic signed [31:0] ang_acc [3];
	logic signed [15:0] goff [3];
	logic cal_busy;

	assign acc_rd = psel & penable & ~pready;
	assign acc_wr = psel & penable & pready & pwrite;

	function automatic logic mtr_mapped(input logic [7:0] a);
		mtr_mapped = (a <= REG_ANG_Z) && (a[1:0] == 2'h0);
	endfunction : mtr_mapped

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= acc_rd;
			pslverr <= acc_rd & (~mtr_mapped(paddr) | (pwrite &
				paddr == REG_BAUD & ~usb_attached));
			if (acc_rd & ~pwrite) begin
				unique case (paddr)
					REG_CTRL: prdata <= {23'h0, cal_busy, ctrl[7:0]};
					REG_ZERO_OFFSET_ADJUST: prdata <= 32'(zero_offset_adjust);
					REG_BAUD: prdata <= {16'h0, baud_div};
					REG_PWM_PER: prdata <= {16'h0, pwm_per};
					REG_PWM_SPAN: prdata <= {24'h0, pwm_span};
					REG_STATUS: prdata <= {left_mm, right_mm, 13'h0,
						marker_right, marker_left, track_present}; // [RULE4]
					REG_GYRO_Z: prdata <= 32'(rate[2]);
					REG_ANG_X: prdata <= ang_acc[0] / mtr_ascale(ctrl[5:4]);
					REG_ANG_Y: prdata <= ang_acc[1] / mtr_ascale(ctrl[5:4]);
					REG_ANG_Z: prdata <= ang_acc[2] / mtr_ascale(ctrl[5:4]);
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			zero_offset_adjust <= 16'sh0000;
			baud_div <= BAUD_DIV_RST; // [RULE1]
			pwm_per <= PWM_PER_RST;
			pwm_span <= PWM_SPAN_RST;
		end else if (acc_wr) begin
			unique case (paddr)
				REG_CTRL: ctrl <= pwdata[8:0];
				REG_ZERO_OFFSET_ADJUST: zero_offset_adjust <= pwdata[15:0];
				REG_BAUD: if (usb_attached) baud_div <= pwdata[15:0]; // [RULE2]
				REG_PWM_PER: pwm_per <= pwdata[15:0];
				REG_PWM_SPAN: pwm_span <= pwdata[7:0];
				default: ;
			endcase
		end else if (ctrl[CB_GCAL] & cal_busy) begin
			ctrl[CB_GCAL] <= 1'b0;
		end
	end
	// ==============================
	// sampling period and scan
	logic [23:0] tcnt;
	logic tick, publish;
	mtr_scan_t st;
	logic [AW-1:0] ridx, sidx;
	logic svalid;
	logic [15:0] rd_word;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tcnt <= 24'h0;
			tick <= 1'b0;
		end else if (tcnt == 24'(SAMPLE_CYC - 1)) begin
			tcnt <= 24'h0;
			tick <= 1'b1; // [RULE21]
		end else begin
			tcnt <= tcnt + 24'h1;
			tick <= 1'b0;
		end
	end

	mtr_sample_ram #(.W(16), .DEPTH(NSENS)) u_ram (
		.ref_clk(ref_clk),
		.wr_en(smp_valid),
		.wr_addr(smp_idx[AW-1:0]),
		.wr_data(smp_data),
		.rd_addr(ridx),
		.rd_data(rd_word)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st <= SC_IDLE;
			ridx <= '0;
			sidx <= '0;
			svalid <= 1'b0;
		end else begin
			svalid <= (st == SC_RUN);
			sidx <= ridx;
			unique case (st)
				SC_IDLE: if (tick) st <= SC_RUN;
				SC_RUN: begin
					ridx <= ridx + 1'b1;
					if (ridx == AW'(NSENS - 1)) st <= SC_WAIT;
				end
				SC_WAIT: st <= SC_DONE;
				SC_DONE: st <= SC_IDLE;
			endcase
		end
	end
	assign publish = (st == SC_DONE);
	// ==============================
	// classification
	logic signed [16:0] s_adj, smax, smin, rel_mid;
	logic is_trk, is_mrk, has_t, has_m;
	logic [AW-1:0] first_t, last_t, first_m, last_m;

	assign s_adj = 17'(signed'(rd_word)) + 17'(zero_offset_adjust); // [RULE10]
	assign is_trk = ctrl[CB_REL] ? (s_adj > rel_mid) : (s_adj > TRK_THR);
	assign is_mrk = ~ctrl[CB_REL] &
		(s_adj < mtr_mrk_thr(ctrl[7:6])); // [RULE9] [RULE11]

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{has_t, has_m} <= 2'h0;
			{first_t, last_t, first_m, last_m} <= '0;
			smax <= 17'sh10000;
			smin <= 17'sh0FFFF;
			rel_mid <= 17'sh00000;
		end else if (tick) begin
			{has_t, has_m} <= 2'h0;
			smax <= 17'sh10000;
			smin <= 17'sh0FFFF;
		end else if (svalid) begin
			if (s_adj > smax) smax <= s_adj;
			if (s_adj < smin) smin <= s_adj;
			if (is_trk) begin
				if (!has_t) first_t <= sidx;
				last_t <= sidx;
				has_t <= 1'b1;
			end
			if (is_mrk) begin
				if (!has_m) first_m <= sidx;
				last_m <= sidx;
				has_m <= 1'b1;
			end
		end else if (publish) begin
			rel_mid <= 17'((18'(smax) + 18'(smin)) >>> 1); // [RULE11]
		end
	end

	function automatic logic signed [7:0] mtr_mm(input logic [AW-1:0] i);
		mtr_mm = 8'(int'(i) * PITCH_MM - CENTER_MM);
	endfunction : mtr_mm
	// ==============================
	// publish results and branch select
	logic sel_right, want_right;
	logic signed [7:0] sel_mm;
	logic signed [31:0] duty_s;

	always_comb begin
		want_right = sel_right;
		if (fork_left & ~fork_right) want_right = 1'b0;
		else if (~fork_left & fork_right) want_right = 1'b1; // [RULE6]
		else if (fork_left & fork_right)
			want_right = ctrl[CB_RX_BRANCH] ? serial_receive_pin :
				ctrl[CB_CMD_RIGHT]; // [RULE7]
	end
	assign sel_mm = !has_t ? 8'sh00 : (want_right ? mtr_mm(last_t) :
		mtr_mm(first_t));
	assign duty_s = signed'(32'(pwm_per >> 1)) + (signed'(32'(pwm_per)) *
		32'(sel_mm) * signed'(32'(pwm_span))) / SPAN_DEN; // [RULE20]

	logic [15:0] duty;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_right <= 1'b0;
			track_present <= 1'b0;
			{marker_left, marker_right} <= 2'h0;
			{left_mm, right_mm} <= 16'h0;
			sel_pos_q <= 8'h0;
			dac_code <= DAC_MID;
			duty <= PWM_PER_RST >> 1;
		end else if (publish) begin
			sel_right <= want_right;
			track_present <= has_t; // [RULE3]
			marker_left <= has_m & (!has_t | first_m < first_t); // [RULE8]
			marker_right <= has_m & has_t & (last_m > last_t);
			left_mm <= has_t ? mtr_mm(first_t) : 8'sh00; // [RULE5]
			right_mm <= has_t ? mtr_mm(last_t) : 8'sh00;
			sel_pos_q <= sel_mm;
			dac_code <= DAC_MID + 8'((16'(sel_mm) * 16'sd27) >>> 4); // [RULE19]
			duty <= 16'(duty_s);
		end
	end
	// ==============================
	// gyroscope
	logic [15:0] graw [3];
	logic cal_pend;
	assign graw = '{gyro_raw_x, gyro_raw_y, gyro_raw_z};
	assign cal_busy = cal_pend;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cal_pend <= 1'b0;
			nv_store <= 1'b0;
			nv_offset_out <= 48'h0;
			for (int a = 0; a < 3; a++) goff[a] <= 16'sh0000;
		end else begin
			nv_store <= 1'b0;
			if (ctrl[CB_GCAL]) cal_pend <= 1'b1;
			if (nv_load) begin
				for (int a = 0; a < 3; a++) goff[a] <= nv_offset_in[16*a +: 16];
			end else if (cal_pend & gyro_valid) begin
				cal_pend <= 1'b0;
				nv_store <= 1'b1; // [RULE15]
				nv_offset_out <= {graw[2], graw[1], graw[0]};
				for (int a = 0; a < 3; a++) goff[a] <= graw[a];
			end
		end
	end

	function automatic logic signed [15:0] mtr_clamp(input logic [15:0] raw,
		input logic signed [15:0] off, input logic [1:0] r);
		logic signed [16:0] d;
		d = 17'(signed'(raw)) - 17'(off);
		if (d > mtr_gspan(r)) d = mtr_gspan(r);
		else if (d < -mtr_gspan(r)) d = -mtr_gspan(r);
		mtr_clamp = 16'(d);
	endfunction : mtr_clamp

	logic [1:0] wsel;
	assign wsel = 2'((paddr - REG_ANG_X) >> 2);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int a = 0; a < 3; a++) begin
				rate[a] <= 16'sh0000;
				ang_acc[a] <= 32'sh0;
			end
		end else begin
			for (int a = 0; a < 3; a++) begin
				if (gyro_valid)
					rate[a] <= mtr_clamp(graw[a], goff[a], ctrl[5:4]); // [RULE12] [RULE13]
				if (acc_wr & paddr >= REG_ANG_X & paddr <= REG_ANG_Z &
					paddr[1:0] == 2'h0 & wsel == 2'(a))
					ang_acc[a] <= signed'(pwdata) * mtr_ascale(ctrl[5:4]);
				else if (tick)
					ang_acc[a] <= ang_acc[a] + 32'(rate[a]); // [RULE14]
			end
		end
	end
	// ==============================
	// pwm and multi-pulse output
	logic [15:0] pcnt;
	logic [2:0] mp_slot;
	logic mp_hi;
	logic [11:0] mp_cnt, mp_len;
	logic [7:0] mp_val;

	always_comb begin
		unique case (mp_slot)
			3'h0: mp_val = 8'(left_mm) ^ 8'h80;
			3'h1: mp_val = 8'(right_mm) ^ 8'h80;
			3'h2: mp_val = {5'h0, marker_right, marker_left, track_present};
			default: mp_val = 8'(rate[2] >>> 8) ^ 8'h80; // [RULE18]
		endcase
	end
	assign mp_len = mp_hi ? MP_BASE_CYC + 12'(mp_val) : MP_GAP_CYC;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pcnt <= 16'h0;
			mp_slot <= MP_SLOTS;
			mp_hi <= 1'b0;
			mp_cnt <= 12'h0;
			multi_pulse_output <= 1'b0;
		end else begin
			pcnt <= (pcnt >= pwm_per - 16'h1) ? 16'h0 : pcnt + 16'h1;
			if (tick) begin
				mp_slot <= 3'h0; // [RULE17]
				mp_hi <= 1'b1;
				mp_cnt <= 12'h0;
			end else if (mp_slot != MP_SLOTS) begin
				mp_cnt <= mp_cnt + 12'h1;
				if (mp_cnt == mp_len - 12'h1) begin
					mp_cnt <= 12'h0;
					mp_hi <= ~mp_hi;
					if (!mp_hi) mp_slot <= mp_slot + 3'h1;
				end
			end
			multi_pulse_output <= ctrl[CB_MULTI] ?
				(mp_hi & mp_slot != MP_SLOTS) : (pcnt < duty); // [RULE19]
		end
	end
	// ==============================
	// indicator led blending
	logic [7:0] lcnt;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lcnt <= 8'h0;
			{led_red, led_green} <= 2'h0;
		end else begin
			lcnt <= lcnt + 8'h1;
			led_red <= track_present & (lcnt < DAC_MID - sel_pos_q); // [RULE16]
			led_green <= track_present & (lcnt < DAC_MID + sel_pos_q);
		end
	end
	// ==============================
	// serial report: left mm, right mm, flags
	logic [15:0] bcnt;
	logic [3:0] bitn;
	logic [1:0] tx_byte;
	logic [9:0] tx_sh;
	logic tx_busy;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			{bcnt, bitn, tx_byte, tx_busy} <= '0;
			tx_sh <= 10'h3FF;
			tx_pin <= 1'b1;
		end else if (!tx_busy) begin
			tx_pin <= 1'b1;
			if (publish) begin
				tx_busy <= 1'b1;
				tx_byte <= 2'h0;
				tx_sh <= {1'b1, 8'(has_t ? mtr_mm(first_t) : 8'sh00), 1'b0};
			end
		end else if (bcnt == baud_div - 16'h1) begin
			bcnt <= 16'h0;
			tx_pin <= tx_sh[0]; // [RULE1]
			tx_sh <= {1'b1, tx_sh[9:1]};
			bitn <= bitn + 4'h1;
			if (bitn == 4'h9) begin
				bitn <= 4'h0;
				tx_byte <= tx_byte + 2'h1;
				tx_busy <= (tx_byte != 2'h2);
				tx_sh <= {1'b1, (tx_byte == 2'h0) ? 8'(right_mm) :
					{5'h0, marker_right, marker_left, track_present}, 1'b0};
			end
		end else begin
			bcnt <= bcnt + 16'h1;
		end
	end
	// ==============================
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_track_flag: assert property (publish |=> track_present == $past(has_t))
		else $error("track flag mismatch"); // [RULE3]
	chk_rel_nomark: assert property (publish & ctrl[CB_REL]
		|=> !marker_left & !marker_right)
		else $error("marker in relative mode"); // [RULE11]
	chk_fork_left: assert property (publish & fork_left & !fork_right
		|=> !sel_right) else $error("left fork not taken"); // [RULE6]
	chk_fork_hold: assert property (publish & !fork_left & !fork_right
		|=> $stable(sel_right)) else $error("branch changed"); // [RULE6]
	chk_baud_lock: assert property (acc_wr & paddr == REG_BAUD & !usb_attached
		|=> $stable(baud_div)) else $error("baud changed"); // [RULE2]
	chk_dac_center: assert property (publish & !has_t
		|=> dac_code == DAC_MID && duty == pwm_per >> 1)
		else $error("no-track output not centred"); // [RULE20]
	chk_rate_span: assert property (gyro_valid |=> // [RULE13]
		rate[2] <= mtr_gspan($past(ctrl[5:4])) &&
		rate[2] >= -mtr_gspan($past(ctrl[5:4])))
		else $error("rate out of span");
	chk_mp_start: assert property (tick ##1 ctrl[CB_MULTI] |-> mp_slot == 3'h0
		##1 multi_pulse_output) else $error("frame start"); // [RULE17]
	chk_scan_pub: assert property (tick |-> ##(NSENS + 2) publish)
		else $error("publish late"); // [RULE21]
	cov_markers: cover property (publish ##1 marker_left & marker_right);
	cov_rx_branch: cover property (publish & fork_left & fork_right &
		ctrl[CB_RX_BRANCH]);
	cov_gyro_cal: cover property (nv_store);
endmodule : mtr_track_readout
`default_nettype wire

// file: tb/mtr_track_readout_tb_top.sv
// self-checking bench for the track readout block
`timescale 1ns/1ns
`default_nettype none
module mtr_track_readout_tb_top import mtr_pkg::*; ;
	localparam int SCYC = 3050;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, dac_code, rx_byte;
	logic [31:0] pwdata, prdata;
	logic smp_valid, gyro_valid, nv_store, fork_left, fork_right;
	logic serial_receive_pin, usb_attached, track_present, marker_left;
	logic marker_right, led_red, led_green, multi_pulse_output, tx_pin;
	logic rx_valid, nv_load;
	logic [3:0] smp_idx;
	logic [15:0] smp_data, gz;
	logic [47:0] nv_offset_out, nv_offset_in;
	logic [15:0] smp [16];
	logic [7:0] rxq [$];
	int failures, checked, gcnt;

	mtr_track_readout #(.SAMPLE_CYC(SCYC), .NSENS(16)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
		.smp_idx(smp_idx), .smp_data(smp_data), .gyro_valid(gyro_valid),
		.gyro_raw_x(16'h0000), .gyro_raw_y(16'h0000), .gyro_raw_z(gz),
		.nv_load(nv_load), .nv_offset_in(nv_offset_in),
		.nv_store(nv_store),
		.nv_offset_out(nv_offset_out), .fork_left(fork_left),
		.fork_right(fork_right), .serial_receive_pin(serial_receive_pin),
		.usb_attached(usb_attached), .track_present(track_present),
		.marker_left(marker_left), .marker_right(marker_right),
		.led_red(led_red), .led_green(led_green), .dac_code(dac_code),
		.multi_pulse_output(multi_pulse_output), .tx_pin(tx_pin)
	);
	mtr_uart_rx_model #(.BIT_CYC(4)) model_u (
		.ref_clk(ref_clk), .tx_pin(tx_pin),
		.rx_valid(rx_valid), .rx_byte(rx_byte)
	);

	// ==============================
	// clock, gyro strobe, serial capture
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		gcnt <= (gcnt == 99) ? 0 : gcnt + 1;
		gyro_valid <= (gcnt == 99);
	end
	always @(posedge rx_valid) rxq.push_back(rx_byte);

	// ==============================
	// helpers
	task automatic results();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string s);
		checked++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic er);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			chk(0, 1, "apb wait");
			results();
		end
	endtask : apb
	task automatic wreg(input logic [7:0] a, input logic [31:0] d,
		input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		chk(e, ee, "write response");
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [31:0] x,
		input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(e, ee, "read response");
		chk(r, x, "read data");
	endtask : rreg
	function automatic logic [7:0] mm(input int i);
		mm = 8'(i * 10 - 75);
	endfunction : mm
	function automatic logic [7:0] dacx(input int i);
		dacx = 8'(128 + (((i * 10 - 75) * 27) >>> 4));
	endfunction : dacx
	task automatic scene(input int a, input int b);
		foreach (smp[k]) smp[k] = 16'h0000;
		smp[a] = 16'h0200;
		smp[b] = 16'h0200;
	endtask : scene
	task automatic load();
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			smp_valid <= 1'b1;
			smp_idx <= 4'(i);
			smp_data <= smp[i];
		end
		@(posedge ref_clk);
		smp_valid <= 1'b0;
		cyc(2 * SCYC + 30);
	endtask : load

	// ==============================
	// scenarios
	task automatic t_reset();
		rreg(REG_CTRL, 32'(CTRL_RST), 1'b0);
		rreg(REG_BAUD, 32'(BAUD_DIV_RST), 1'b0);
		rreg(REG_PWM_PER, 32'(PWM_PER_RST), 1'b0);
		rreg(REG_PWM_SPAN, 32'(PWM_SPAN_RST), 1'b0);
		rreg(8'h28, 32'h0, 1'b1);
		rreg(8'h06, 32'h0, 1'b1);
		chk(tx_pin, 1'b1, "serial idle");
		$display("test reset done");
	endtask : t_reset
	task automatic t_baud();
		wreg(REG_BAUD, 32'h4, 1'b1);
		rreg(REG_BAUD, 32'(BAUD_DIV_RST), 1'b0);
		@(posedge ref_clk) usb_attached <= 1'b1;
		wreg(REG_BAUD, 32'h4, 1'b0);
		@(posedge ref_clk) usb_attached <= 1'b0;
		rreg(REG_BAUD, 32'h4, 1'b0);
		$display("test baud done");
	endtask : t_baud
	task automatic t_track(input int i);
		int r, g, w1, w2, n, lo, hit;
		scene(i, i);
		load();
		chk(track_present, 1'b1, "track present");
		chk(dac_code, dacx(i), "analog level");
		rreg(REG_STATUS, {mm(i), mm(i), 16'h0001}, 1'b0);
		r = 0;
		g = 0;
		repeat (256) begin
			@(posedge ref_clk);
			r += led_red;
			g += led_green;
		end
		chk((i < 8) ? r > g : g > r, 1'b1, "led blend");
		rxq.delete();
		cyc(SCYC + 200);
		hit = 0;
		for (int k = 0; k + 2 < rxq.size(); k++)
			if (rxq[k] === mm(i) && rxq[k + 1] === mm(i) && rxq[k + 2] === 8'h01)
				hit = 1;
		chk(hit, 1, "serial report");
		lo = 0;
		n = 0;
		w1 = 0;
		w2 = 0;
		while (n < 2 * SCYC && !(lo > 300 && multi_pulse_output === 1'b1)) begin
			lo = (multi_pulse_output === 1'b1) ? 0 : lo + 1;
			@(posedge ref_clk);
			n++;
		end
		while (multi_pulse_output === 1'b1 && w1 < 1000) begin
			w1++;
			@(posedge ref_clk);
		end
		while (multi_pulse_output !== 1'b1 && n < 3 * SCYC) begin
			n++;
			@(posedge ref_clk);
		end
		while (multi_pulse_output === 1'b1 && w2 < 1000) begin
			w2++;
			@(posedge ref_clk);
		end
		chk(w1, int'(MP_BASE_CYC) + int'(mm(i) ^ 8'h80), "slot one");
		chk(w2, int'(MP_BASE_CYC) + int'(mm(i) ^ 8'h80), "slot two");
		$display("test track %0d done", i);
	endtask : t_track
	task automatic t_fork();
		logic [1:0] fk [6] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b11, 2'b11};
		logic [31:0] cw [6] = '{32'h08, 32'h08, 32'h08, 32'h08, 32'h0A, 32'h0E};
		int want [6] = '{3, 3, 12, 3, 12, 3};
		scene(3, 12);
		load();
		rreg(REG_STATUS, {mm(3), mm(12), 16'h0001}, 1'b0);
		for (int k = 0; k < 6; k++) begin
			wreg(REG_CTRL, cw[k], 1'b0);
			@(posedge ref_clk);
			fork_left <= fk[k][1];
			fork_right <= fk[k][0];
			cyc(SCYC + 30);
			chk(dac_code, dacx(want[k]), "branch");
		end
		@(posedge ref_clk) serial_receive_pin <= 1'b1;
		cyc(SCYC + 30);
		chk(dac_code, dacx(12), "receive pin branch");
		$display("test fork done");
	endtask : t_fork
	task automatic t_marker();
		scene(8, 8);
		smp[2] = 16'hFE80;
		smp[14] = 16'hFB00;
		load();
		rreg(REG_STATUS, {mm(8), mm(8), 16'h0007}, 1'b0);
		for (int s = 0; s < 3; s++) begin
			wreg(REG_CTRL, 32'h08 | 32'(s << 6), 1'b0);
			cyc(SCYC + 30);
			chk(marker_left, s == 0, "left marker");
			chk(marker_right, 1'b1, "right marker");
		end
		wreg(REG_CTRL, 32'h48, 1'b0);
		wreg(REG_ZERO_OFFSET_ADJUST, 32'hFFFFFF00, 1'b0);
		cyc(SCYC + 30);
		chk(marker_left, 1'b1, "shifted marker");
		wreg(REG_CTRL, 32'h09, 1'b0);
		cyc(2 * SCYC + 30);
		chk({track_present, marker_left, marker_right}, 3'b100, "rel");
		wreg(REG_ZERO_OFFSET_ADJUST, 32'h0, 1'b0);
		wreg(REG_CTRL, 32'h08, 1'b0);
		scene(0, 0);
		smp[0] = 16'h0000;
		smp[5] = 16'h0060;
		load();
		chk(track_present, 1'b0, "below track level");
		wreg(REG_ZERO_OFFSET_ADJUST, 32'h30, 1'b0);
		cyc(SCYC + 30);
		chk(track_present, 1'b1, "raised track");
		$display("test marker done");
	endtask : t_marker
	task automatic t_pwm();
		int h;
		wreg(REG_ZERO_OFFSET_ADJUST, 32'h0, 1'b0);
		cyc(SCYC + 30);
		chk(track_present, 1'b0, "no track");
		chk(dac_code, 32'(DAC_MID), "centred analog");
		wreg(REG_CTRL, 32'h00, 1'b0);
		wreg(REG_PWM_PER, 32'd400, 1'b0);
		rreg(REG_PWM_PER, 32'd400, 1'b0);
		cyc(SCYC + 30);
		h = 0;
		repeat (400) begin
			@(posedge ref_clk);
			h += multi_pulse_output + led_red + led_green;
		end
		chk(h, 200, "half duty");
		$display("test pwm done");
	endtask : t_pwm
	task automatic t_gyro();
		logic [31:0] sp [3] = '{32'd25000, 32'd5000, 32'd20000};
		int n;
		@(posedge ref_clk) gz <= 16'h7FFF;
		for (int r = 0; r < 3; r++) begin
			wreg(REG_CTRL, 32'h08 | 32'(r << 4), 1'b0);
			cyc(SCYC + 30);
			rreg(REG_GYRO_Z, sp[r], 1'b0);
		end
		@(posedge ref_clk) gz <= 16'h8000;
		cyc(SCYC + 30);
		rreg(REG_GYRO_Z, -sp[2], 1'b0);
		@(posedge ref_clk) gz <= 16'h0040;
		wreg(REG_CTRL, 32'h108, 1'b0);
		n = 0;
		while (nv_store !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		chk(n < 400, 1'b1, "offset saved");
		chk(nv_offset_out[47:32], 16'h0040, "saved offset");
		cyc(SCYC + 30);
		rreg(REG_GYRO_Z, 32'h0, 1'b0);
		wreg(REG_ANG_Z, 32'd900, 1'b0);
		cyc(SCYC + 30);
		rreg(REG_ANG_Z, 32'd900, 1'b0);
		nv_offset_in <= 48'h0010_0000_0000;
		@(posedge ref_clk) nv_load <= 1'b1;
		@(posedge ref_clk) nv_load <= 1'b0;
		cyc(130);
		rreg(REG_GYRO_Z, 32'h30, 1'b0);
		$display("test gyro done");
	endtask : t_gyro

	initial begin
		{psel, penable, pwrite, smp_valid, gyro_valid} = 5'h00;
		{fork_right, serial_receive_pin, usb_attached, nv_load} = 4'h0;
		nv_offset_in = 48'h0;
		fork_left = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		smp_idx = 4'h0;
		smp_data = 16'h0000;
		gz = 16'h0000;
		gcnt = 0;
		failures = 0;
		checked = 0;
		rst = 1'b1;
		cyc(10);
		rst <= 1'b0;
		t_reset();
		t_baud();
		t_track(1);
		t_track(14);
		t_fork();
		t_marker();
		t_pwm();
		t_gyro();
		results();
	end
endmodule : mtr_track_readout_tb_top
`default_nettype wire

// file: tb/mtr_uart_rx_model.sv
// host-side serial receiver watching the transmit line
`timescale 1ns/1ns
`default_nettype none
module mtr_uart_rx_model #(
	parameter int BIT_CYC = 4
) (
	// clock
	input wire logic ref_clk,
	// line from the block
	input wire logic tx_pin,
	// decoded bytes
	output logic rx_valid,
	output logic [7:0] rx_byte
);
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		forever begin
			@(negedge tx_pin);
			repeat (BIT_CYC / 2) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge ref_clk);
				rx_byte[i] = tx_pin; // lsb first
			end
			repeat (BIT_CYC) @(posedge ref_clk);
			// no parity, one stop bit
			rx_valid = (tx_pin === 1'b1);
			@(posedge ref_clk);
			rx_valid = 1'b0;
		end
	end
endmodule : mtr_uart_rx_model
`default_nettype wire
